// ---- include/dac_ctl_cfg.svh ----
// Purpose: Offsets, field positions and reset values of the DAC control logic
// Assumes: 24-bit frames, 3-bit register address, 18-bit codes
// Notes:   Definitions only
`ifndef DAC_CTL_CFG_SVH
`define DAC_CTL_CFG_SVH
`define FRAME_BITS      5'd24
`define FRAME_RW_BIT    23
`define FRAME_ADDR_MSB  22
`define FRAME_ADDR_LSB  20
`define FRAME_DATA_MSB  19
`define FRAME_DATA_LSB  0
`define CODE_MSB        19
`define CODE_LSB        2
`define ADDR_DAC        3'h1
`define ADDR_CTRL       3'h2
`define ADDR_CLEAR      3'h3
`define ADDR_SOFT       3'h4
`define SOFT_UPDATE_BIT 0
`define SOFT_CLEAR_BIT  1
`define SOFT_RESET_BIT  2
`define CTRL_FB_BIT     1
`define CTRL_CLAMP_BIT  2
`define CTRL_FLOAT_BIT  3
`define CTRL_FMT_BIT    4
`define CTRL_SDOOFF_BIT 5
`define CTRL_RESET      6'h0c
`define DAC_RESET       18'h20000
`define CLEAR_RESET     18'h00000
`define SIGN_FLIP       18'h20000
`endif

// ---- include/dac_ctl_pkg.sv ----
// Purpose: Types shared by the DAC control logic
// Assumes: dac_ctl_cfg.svh holds the register addresses other than addr_nop
// Notes:   State is one packed struct
`include "dac_ctl_cfg.svh"
package dac_ctl_pkg;
  typedef enum logic [2:0] {
    addr_nop   = 3'h0,
    addr_dac   = `ADDR_DAC,
    addr_ctrl  = `ADDR_CTRL,
    addr_clear = `ADDR_CLEAR,
    addr_soft  = `ADDR_SOFT
  } reg_addr_t;

  typedef struct packed {
    logic [4:0]  s1;        // sclk, sync_n, sdin, update_n, clear_n
    logic [4:0]  s2;
    logic        sclk_d;
    logic        sync_d;
    logic [23:0] shift_in;
    logic [4:0]  count;
    logic [23:0] shift_out;
    logic [17:0] pending;
    logic [17:0] dac;
    logic [17:0] clear_code;
    logic [5:0]  ctrl;
    logic [17:0] analog_code;
  } state_t;
endpackage : dac_ctl_pkg

// ---- rtl/dac_ctl.sv ----
// Purpose: Register and output-state control of an 18-bit voltage DAC
// Assumes: Serial pins and control pins are asynchronous; sampled by clock
// Notes:   Frame taken at sync_n rise after exactly 24 falling sclk edges
// How it works
// RULE_01 - Soft control register is write only; bits act like pulsing the pins low.
// RULE_02 - Bit 0 written 1 moves pending value into the DAC register.
// RULE_03 - Bit 1 written 1 loads the 18-bit clear code into the DAC register.
// RULE_04 - Cleared output is read through the current coding selection.
// RULE_05 - Bit 2 written 1 returns everything to power-on defaults.
// RULE_06 - Soft clear is ignored while the update pin is held low.
// RULE_07 - Soft update is ignored while the clear pin is held low.
// RULE_08 - At reset: defaults, output floated and clamped to ground.
// RULE_09 - Float and clamp persist until the control register changes them.
// RULE_10 - Host clears float and clamp bits before programming output values.
// RULE_11 - After release the output sits at the low reference unless loaded.
// RULE_12 - Clamp wins; float alone floats; neither gives normal output.
// RULE_13 - Feedback resistor select 1 connects internal matched resistors.
// RULE_14 - Host clears feedback resistor select for gain of two.
// RULE_15 - Coding select defaults to 0, twos complement; 1 is offset binary.
// RULE_16 - Top frame bit 0 writes, 1 requests a read.
// RULE_17 - Frame is direction, 3-bit address, 20 data bits; reserved ignored.
// RULE_18 - Soft action bits are one-cycle strobes, never stored.
`timescale 1ns/10ps
`include "dac_ctl_cfg.svh"
module dac_ctl (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        sclk,
  input  wire logic        sync_n,
  input  wire logic        sdin,
  output logic             sdo,
  output logic             sdo_oe,
  input  wire logic        output_update_strobe_n,
  input  wire logic        clear_code_load_n,
  output logic [17:0]      analog_code,
  output logic             code_format_select,
  output logic             feedback_resistor_select,
  output logic             output_float_select,
  output logic             output_ground_clamp,
  output logic             output_normal,
  output logic             output_floating,
  output logic             output_clamped
);
  dac_ctl_pkg::state_t q_ff;
  dac_ctl_pkg::state_t nxt_q;

  logic                   sclk_s;
  logic                   sync_s;
  logic                   sdin_s;
  logic                   upd_pin_low;
  logic                   clr_pin_low;
  logic                   sclk_fall;
  logic                   frame_end;
  logic                   frame_rw;
  dac_ctl_pkg::reg_addr_t frame_addr;
  logic [19:0]            frame_data;
  logic                   soft_update;
  logic                   soft_clear;
  logic                   soft_reset;

  assign sclk_s      = q_ff.s2[4];
  assign sync_s      = q_ff.s2[3];
  assign sdin_s      = q_ff.s2[2];
  assign upd_pin_low = ~q_ff.s2[1];
  assign clr_pin_low = ~q_ff.s2[0];
  assign sclk_fall   = q_ff.sclk_d & ~sclk_s & ~sync_s;
  assign frame_end   = sync_s & ~q_ff.sync_d & (q_ff.count == `FRAME_BITS);
  assign frame_rw    = q_ff.shift_in[`FRAME_RW_BIT];                              // [RULE_16]
  assign frame_addr  = dac_ctl_pkg::reg_addr_t'(q_ff.shift_in[`FRAME_ADDR_MSB:`FRAME_ADDR_LSB]);
  assign frame_data  = q_ff.shift_in[`FRAME_DATA_MSB:`FRAME_DATA_LSB];            // [RULE_17]

  // Strobes live for this cycle only, nothing stores them
  assign soft_update = frame_end & ~frame_rw & (frame_addr == dac_ctl_pkg::addr_soft)
                     & frame_data[`SOFT_UPDATE_BIT] & ~clr_pin_low;                // [RULE_07] [RULE_18]
  assign soft_clear  = frame_end & ~frame_rw & (frame_addr == dac_ctl_pkg::addr_soft)
                     & frame_data[`SOFT_CLEAR_BIT] & ~upd_pin_low;                 // [RULE_06] [RULE_18]
  assign soft_reset  = frame_end & ~frame_rw & (frame_addr == dac_ctl_pkg::addr_soft)
                     & frame_data[`SOFT_RESET_BIT];                                // [RULE_05]

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_q        = q_ff;
    nxt_q.s1     = {sclk, sync_n, sdin, output_update_strobe_n, clear_code_load_n};
    nxt_q.s2     = q_ff.s1;
    nxt_q.sclk_d = sclk_s;
    nxt_q.sync_d = sync_s;
    // Frame start resets the bit count
    if (~sync_s && q_ff.sync_d) begin
      nxt_q.count = 5'h00;
    end else if (sclk_fall) begin
      nxt_q.shift_in  = {q_ff.shift_in[22:0], sdin_s};
      nxt_q.shift_out = {q_ff.shift_out[22:0], 1'b0};
      // Saturate so an overlong frame is dropped, not wrapped
      if (q_ff.count != 5'h1f) begin
        nxt_q.count = q_ff.count + 5'h01;
      end
    end
    if (frame_end) begin
      if (frame_rw) begin
        nxt_q.shift_out = q_ff.shift_in;
        case (frame_addr)
          dac_ctl_pkg::addr_dac:   nxt_q.shift_out[`CODE_MSB:`CODE_LSB] = q_ff.dac;
          dac_ctl_pkg::addr_ctrl:  nxt_q.shift_out[19:0] = {14'h0000, q_ff.ctrl};
          dac_ctl_pkg::addr_clear: nxt_q.shift_out[`CODE_MSB:`CODE_LSB] = q_ff.clear_code;
          default:                 nxt_q.shift_out[19:0] = 20'h00000;             // [RULE_01]
        endcase
      end else begin
        case (frame_addr)
          dac_ctl_pkg::addr_dac:   nxt_q.pending = frame_data[`CODE_MSB:`CODE_LSB];
          dac_ctl_pkg::addr_ctrl:  nxt_q.ctrl = frame_data[5:0];                   // [RULE_09]
          dac_ctl_pkg::addr_clear: nxt_q.clear_code = frame_data[`CODE_MSB:`CODE_LSB]; // [RULE_03]
          default:                 nxt_q.ctrl = q_ff.ctrl;
        endcase
      end
    end
    // Pin held low acts on every cycle; clear pin outranks update pin
    if (clr_pin_low || soft_clear) begin
      nxt_q.dac = q_ff.clear_code;                                                 // [RULE_03]
    end else if (upd_pin_low || soft_update) begin
      nxt_q.dac = q_ff.pending;                                                    // [RULE_02] [RULE_01]
    end
    if (soft_reset) begin
      nxt_q.pending    = `DAC_RESET;                                               // [RULE_05]
      nxt_q.dac        = `DAC_RESET;
      nxt_q.clear_code = `CLEAR_RESET;
      nxt_q.ctrl       = `CTRL_RESET;
      nxt_q.shift_out  = 24'h000000;
    end
    // Analog core wants offset binary; twos complement flips the sign bit
    nxt_q.analog_code = nxt_q.ctrl[`CTRL_FMT_BIT] ? nxt_q.dac
                                                  : (nxt_q.dac ^ `SIGN_FLIP);     // [RULE_04] [RULE_11]
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      q_ff             <= '0;                                                      // [RULE_08]
      q_ff.s1          <= 5'h1f;
      q_ff.s2          <= 5'h1f;
      q_ff.sync_d      <= 1'b1;
      q_ff.pending     <= `DAC_RESET;
      q_ff.dac         <= `DAC_RESET;                                              // [RULE_11]
      q_ff.clear_code  <= `CLEAR_RESET;
      q_ff.ctrl        <= `CTRL_RESET;                                             // [RULE_15]
      q_ff.analog_code <= 18'h00000;
    end else begin
      q_ff <= nxt_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  assign sdo                      = q_ff.shift_out[23];
  assign sdo_oe                   = ~sync_s & ~q_ff.ctrl[`CTRL_SDOOFF_BIT];
  assign analog_code              = q_ff.analog_code;
  assign code_format_select       = q_ff.ctrl[`CTRL_FMT_BIT];                      // [RULE_15]
  assign feedback_resistor_select = q_ff.ctrl[`CTRL_FB_BIT];                       // [RULE_13]
  assign output_float_select      = q_ff.ctrl[`CTRL_FLOAT_BIT];
  assign output_ground_clamp      = q_ff.ctrl[`CTRL_CLAMP_BIT];
  assign output_clamped           = output_ground_clamp;                           // [RULE_12]
  assign output_floating          = output_float_select & ~output_ground_clamp;    // [RULE_12]
  assign output_normal            = ~output_float_select & ~output_ground_clamp;   // [RULE_12]

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_reset_state: assert property ($past(rst) |-> output_clamped && output_float_select // [RULE_08]
    && !code_format_select && analog_code == 18'h00000)
    else $error("Reset state wrong");
  a_clamp_holds: assert property (!frame_end && !soft_reset |=> $stable(q_ff.ctrl)) // [RULE_09]
    else $error("Control changed without a write");
  a_soft_update: assert property (soft_update && !soft_clear && !soft_reset // [RULE_02]
    |=> q_ff.dac == $past(q_ff.pending))
    else $error("Soft update missed");
  a_soft_clear: assert property (soft_clear && !soft_reset |=> q_ff.dac == $past(q_ff.clear_code)) // [RULE_03]
    else $error("Soft clear missed");
  a_clear_blocked: assert property (upd_pin_low && frame_end // [RULE_06]
    && frame_addr == dac_ctl_pkg::addr_soft |-> !soft_clear)
    else $error("Soft clear not blocked");
  a_update_blocked: assert property (clr_pin_low |-> !soft_update) // [RULE_07]
    else $error("Soft update not blocked");
  a_soft_reset: assert property (soft_reset |=> q_ff.ctrl == `CTRL_RESET // [RULE_05]
    && q_ff.dac == `DAC_RESET ##1 analog_code == 18'h00000)
    else $error("Soft reset incomplete");
  a_out_state: assert property ((output_normal + output_floating + output_clamped) == 2'd1) // [RULE_12]
    else $error("Output state not one-hot");
  // Pins held low move the DAC register without a frame, so compare like cycles
  a_code_format: assert property (!soft_reset && !frame_end |=> analog_code == // [RULE_04]
    (code_format_select ? q_ff.dac : (q_ff.dac ^ `SIGN_FLIP)))
    else $error("Coding mismatch");
  a_no_store: assert property (frame_end && frame_addr == dac_ctl_pkg::addr_soft // [RULE_18]
    && !frame_rw && !soft_reset |=> $stable(q_ff.pending) && $stable(q_ff.clear_code))
    else $error("Soft write stored a value");
endmodule : dac_ctl

// ---- tb/dac_ctl_tb.sv ----
// Purpose: Self-checking bench of the DAC control logic
// Assumes: Registers written through serial frames; the DAC register is also loaded by the pins
// Notes:   Seeded random codes mixed with corner cases
`timescale 1ns/10ps
module dac_ctl_tb;
  logic        clock, rst, sclk, sync_n, sdin, sdo, sdo_oe, upd_n, clr_n;
  logic [17:0] analog_code, code, cc;
  logic        fmt, fb, flt, gnd, o_nrm, o_flt, o_clp;
  logic [23:0] r;
  int          n_errors, n_compared;
  dac_ctl uut (.clock, .rst, .sclk, .sync_n, .sdin, .sdo, .sdo_oe, .analog_code,
    .output_update_strobe_n(upd_n), .clear_code_load_n(clr_n), .code_format_select(fmt),
    .feedback_resistor_select(fb), .output_float_select(flt), .output_ground_clamp(gnd),
    .output_normal(o_nrm), .output_floating(o_flt), .output_clamped(o_clp));
  dac_host host (.clock, .sclk, .sync_n, .sdin, .sdo);
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  function automatic logic [23:0] oc(input logic [17:0] d, input logic ob);
    return {6'h0, ob ? d : d ^ 18'h20000};
  endfunction : oc
  task automatic wr(input logic [2:0] a, input logic [19:0] d);
    host.xfer({1'b0, a, d}, r);
  endtask : wr
  task automatic ana(input logic [23:0] exp);
    chk("analog", exp, {6'h0, analog_code});
  endtask : ana
  task automatic st(input logic [2:0] exp);
    chk("state", {21'h0, exp}, {21'h0, o_nrm, o_flt, o_clp});
  endtask : st
  task automatic cfg(input logic [3:0] exp);
    chk("ctrl", {20'h0, exp}, {20'h0, flt, gnd, fmt, fb});
  endtask : cfg
  task automatic end_of_test();
    $display("n_errors %0d n_compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  //////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // About 25 frames of 2 us each
  initial begin
    #500000;
    n_errors++;
    end_of_test();
  end
  initial begin
    rst = 1'b1;
    upd_n = 1'b1;
    clr_n = 1'b1;
    void'($urandom(66));
    repeat (5) @(posedge clock);
    #1 rst = 1'b0;
    repeat (6) @(posedge clock);
    cfg(4'b1100);
    ana(24'h0);
    st(3'b001);
    code = 18'($urandom);
    wr(3'h1, {code, 2'b00});
    ana(24'h0);
    st(3'b001);
    for (int i = 3; i >= 0; i--) begin
      wr(3'h2, {16'h0, i[1:0], 2'b00});
      st(i[0] ? 3'b001 : (i[1] ? 3'b010 : 3'b100));
    end
    ana(24'h0);
    for (int i = 0; i < 4; i++) begin
      code = (i == 0) ? 18'h3ffff : 18'($urandom);
      wr(3'h1, {code, 2'b00});
      wr(3'h4, 20'h1);
      ana(oc(code, 1'b0));
    end
    cc = 18'($urandom);
    wr(3'h3, {cc, 2'b11});
    wr(3'h2, {15'h0, 1'b1, 2'b00, code[0], 1'b0});
    cfg({3'b001, code[0]});
    wr(3'h4, 20'h2);
    ana(oc(cc, 1'b1));
    wr(3'h1, {~code, 2'b00});
    @(posedge clock) #1 clr_n = 1'b0;
    wr(3'h4, 20'h1);
    ana(oc(cc, 1'b1));
    @(posedge clock) #1 clr_n = 1'b1;
    upd_n = 1'b0;
    wr(3'h4, 20'h2);
    ana(oc(~code, 1'b1));
    @(posedge clock) #1 upd_n = 1'b1;
    wr(3'h4, 20'hffff8);
    ana(oc(~code, 1'b1));
    host.xfer({1'b1, 3'h3, 20'h0}, r);
    host.xfer(24'h0, r);
    chk("clear readback", {3'h0, 3'h3, cc}, {3'h0, r[22:2]});
    host.xfer({1'b1, 3'h4, 20'h0}, r);
    host.xfer(24'h0, r);
    chk("soft readback", 24'h0, {4'h0, r[19:0]});
    chk("sdo_oe idle", 24'h0, {23'h0, sdo_oe});
    wr(3'h4, 20'h4);
    cfg(4'b1100);
    ana(24'h0);
    st(3'b001);
    end_of_test();
  end
endmodule : dac_ctl_tb

// ---- tb/dac_host.sv ----
// Purpose: Host serial controller model for the DAC control logic
// Assumes: Clock-driven timing, sclk period 8 clocks
// Notes:   sclk idles high and stands still between frames
`timescale 1ns/10ps
module dac_host (
  input  wire logic clock,
  output logic      sclk,
  output logic      sync_n,
  output logic      sdin,
  input  wire logic sdo
);
  initial begin
    sclk = 1'b1;
    sync_n = 1'b1;
    sdin = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////
  // Bit 23 picks write or read; MSB first, sampled on the fall
  task automatic xfer(input logic [23:0] f, output logic [23:0] r);
    @(posedge clock) #1 sync_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdin = f[i];
      repeat (4) @(posedge clock);
      #1 r[i] = sdo;
      sclk = 1'b0;
      repeat (4) @(posedge clock);
      #1 sclk = 1'b1;
    end
    repeat (4) @(posedge clock);
    #1 sync_n = 1'b1;
    // Stale data would mask a late sample
    sdin = ~f[0];
    repeat (10) @(posedge clock);
  endtask : xfer
endmodule : dac_host
